// *** rtl/pppm_pkg.sv ***
package pppm_pkg;
  // -------------------------------------------------------------
  // register map
  // -------------------------------------------------------------
  localparam int          ADDR_W       = 4;
  localparam logic [3:0]  OFS_CMDQ     = 4'h0;
  localparam logic [3:0]  OFS_DCR      = 4'h2;
  localparam logic [3:0]  OFS_EPP_ADDR = 4'h3;
  localparam logic [3:0]  OFS_LANE0    = 4'h4;
  localparam logic [3:0]  OFS_LANE3    = 4'h7;
  localparam logic [3:0]  OFS_QUEUE    = 4'h8;
  localparam logic [3:0]  OFS_ECR      = 4'hA;
  // field positions and reset values
  localparam int          DCR_DIR_BIT  = 5;
  localparam int          DCR_BUSY_BIT = 0;
  localparam int          ECR_MODE_HI  = 7;
  localparam int          ECR_MODE_LO  = 5;
  localparam int          ECR_FULL_BIT = 1;
  localparam int          ECR_EMPTY_BIT = 0;
  localparam logic [2:0]  MODE_RST     = 3'h0;
  localparam logic        DIR_RST      = 1'b0;
  // fifo shape
  localparam int          FIFO_DEPTH   = 16;
  localparam int          PTR_W        = 4;
  localparam logic [4:0]  CNT_FULL     = 5'h10;

  // port modes from the extended control register
  typedef enum logic [2:0] {
    PPPM_SPP   = 3'b000,
    PPPM_BYTE  = 3'b001,
    PPPM_PFIFO = 3'b010,
    PPPM_ECP   = 3'b011,
    PPPM_EPP   = 3'b100,
    PPPM_RSV5  = 3'b101,
    PPPM_TEST  = 3'b110,
    PPPM_RSV7  = 3'b111
  } pppm_mode_t;

  // queue port selected at the shared offset
  typedef enum logic [2:0] {
    PPPM_Q_NONE, PPPM_Q_PAYF, PPPM_Q_PAYR, PPPM_Q_COMPAT, PPPM_Q_LOOP
  } pppm_qsel_t;

  // peripheral cycle kinds
  typedef enum logic [2:0] {
    PPPM_K_ADDR_WR, PPPM_K_ADDR_RD, PPPM_K_DATA_WR, PPPM_K_DATA_RD,
    PPPM_K_FWD, PPPM_K_REV
  } pppm_kind_t;

  // cycle engine states
  typedef enum logic [2:0] {
    PPPM_IDLE = 3'b001,
    PPPM_REQ  = 3'b010,
    PPPM_REL  = 3'b100
  } pppm_state_t;

  // fifo entry: byte plus command tag
  typedef struct packed {
    logic       cmd;
    logic [7:0] data;
  } pppm_entry_t;

  // one peripheral cycle
  typedef struct packed {
    pppm_kind_t kind;
    logic [1:0] lane;
    logic       cmd;
    logic [7:0] data;
  } pppm_cyc_t;
endpackage : pppm_pkg

// *** rtl/pppm_data_regs.sv ***
`timescale 1ns/100ps
module pppm_data_regs (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rstn,
  // register port
  input  wire logic [pppm_pkg::ADDR_W-1:0] addr,
  input  wire logic [7:0]                 wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic      [7:0]                 rdata,
  // peripheral cycle handshake
  output logic                            per_req,
  output pppm_pkg::pppm_cyc_t             per_cyc,
  input  wire logic                       per_ack,
  // parallel data lines
  input  wire logic [7:0]                 pd_in,
  output logic      [7:0]                 pd_out,
  output logic                            pd_oe_n
);
  // -------------------------------------------------------------
  // decode helpers
  // -------------------------------------------------------------
  function automatic pppm_pkg::pppm_qsel_t q_sel(input logic [2:0] m, input logic d);
    case (m)
      pppm_pkg::PPPM_ECP:   q_sel = d ? pppm_pkg::PPPM_Q_PAYR : pppm_pkg::PPPM_Q_PAYF;
      pppm_pkg::PPPM_PFIFO: q_sel = pppm_pkg::PPPM_Q_COMPAT;
      pppm_pkg::PPPM_TEST:  q_sel = pppm_pkg::PPPM_Q_LOOP;
      default:              q_sel = pppm_pkg::PPPM_Q_NONE;
    endcase
  endfunction : q_sel

  function automatic logic is_epp(input logic [3:0] a);
    is_epp = (a >= pppm_pkg::OFS_EPP_ADDR) && (a <= pppm_pkg::OFS_LANE3);
  endfunction : is_epp

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  logic [2:0]            mode;
  logic                  dir;
  logic [1:0]            ack_m, ack_s;
  logic [7:0]            pd_m, pd_s;
  pppm_pkg::pppm_state_t st;
  pppm_pkg::pppm_entry_t mem [pppm_pkg::FIFO_DEPTH];
  logic [pppm_pkg::PTR_W-1:0] wp, rp;
  logic [4:0]            cnt;
  logic [7:0]            epp_addr;
  logic [31:0]           epp_word;
  logic                  full, empty, idle;
  pppm_pkg::pppm_qsel_t  qs;
  logic                  in_epp, in_ecp;
  logic                  epp_go, fwd_go, rev_go, rev_done;
  logic                  h_push, h_pop, push, pop;
  pppm_pkg::pppm_entry_t push_ent;
  pppm_pkg::pppm_cyc_t   next_cyc;

  assign full   = (cnt == pppm_pkg::CNT_FULL);
  assign empty  = (cnt == 5'h00);
  assign idle   = (st == pppm_pkg::PPPM_IDLE);
  assign qs     = q_sel(mode, dir);
  assign in_epp = (mode == pppm_pkg::PPPM_EPP);
  assign in_ecp = (mode == pppm_pkg::PPPM_ECP);
  assign per_req = (st == pppm_pkg::PPPM_REQ);

  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_m <= 2'h0;
      pd_m  <= 8'h00;
      pd_s  <= 8'h00;
    end else begin
      ack_m <= {ack_m[0], per_ack};
      pd_m  <= pd_in;
      pd_s  <= pd_m;
    end
  end
  assign ack_s = ack_m;

  // -------------------------------------------------------------
  // mode and direction registers
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode <= pppm_pkg::MODE_RST;
      dir  <= pppm_pkg::DIR_RST;
    end else if (wr && addr == pppm_pkg::OFS_ECR) begin
      mode <= wdata[pppm_pkg::ECR_MODE_HI:pppm_pkg::ECR_MODE_LO];
    end else if (wr && addr == pppm_pkg::OFS_DCR) begin
      dir  <= wdata[pppm_pkg::DCR_DIR_BIT];
    end
  end

  // -------------------------------------------------------------
  // fifo push and pop steering
  // -------------------------------------------------------------
  always_comb begin
    h_push   = 1'b0;
    h_pop    = 1'b0;
    push_ent = '{cmd: 1'b0, data: wdata};
    if (wr && addr == pppm_pkg::OFS_CMDQ && in_ecp && !dir) begin
      h_push       = !full;
      push_ent.cmd = 1'b1;
    end else if (wr && addr == pppm_pkg::OFS_QUEUE) begin
      // payload writes in reverse are dropped
      h_push = !full && (qs == pppm_pkg::PPPM_Q_PAYF
             || qs == pppm_pkg::PPPM_Q_COMPAT
             || qs == pppm_pkg::PPPM_Q_LOOP);
    end
    if (rd && addr == pppm_pkg::OFS_QUEUE) begin
      // forward payload and compat reads leave the fifo alone
      h_pop = !empty && (qs == pppm_pkg::PPPM_Q_PAYR
            || qs == pppm_pkg::PPPM_Q_LOOP);
    end
    if (rev_done) begin
      push_ent = '{cmd: 1'b0, data: pd_s};
    end
  end
  assign push = h_push || rev_done;
  assign pop  = h_pop || fwd_go;

  // -------------------------------------------------------------
  // fifo storage and pointers
  // -------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= push_ent;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= 5'h00;
    end else if (mode == pppm_pkg::PPPM_SPP || mode == pppm_pkg::PPPM_BYTE) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= 5'h00;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
      end
      cnt <= cnt + 5'(push) - 5'(pop);
    end
  end

  // -------------------------------------------------------------
  // cable cycle launch
  // -------------------------------------------------------------
  assign epp_go = idle && in_epp && (wr || rd) && is_epp(addr);
  assign fwd_go = idle && !empty && ((in_ecp && !dir)
                || mode == pppm_pkg::PPPM_PFIFO);
  assign rev_go = idle && in_ecp && dir && !full;
  assign rev_done = (st == pppm_pkg::PPPM_REQ) && ack_s[1]
                  && per_cyc.kind == pppm_pkg::PPPM_K_REV;

  always_comb begin
    next_cyc = per_cyc;
    if (epp_go) begin
      next_cyc.lane = addr[1:0];
      next_cyc.cmd  = 1'b0;
      next_cyc.data = wdata;
      if (addr == pppm_pkg::OFS_EPP_ADDR) begin
        next_cyc.kind = wr ? pppm_pkg::PPPM_K_ADDR_WR : pppm_pkg::PPPM_K_ADDR_RD;
      end else begin
        next_cyc.kind = wr ? pppm_pkg::PPPM_K_DATA_WR : pppm_pkg::PPPM_K_DATA_RD;
      end
    end else if (fwd_go) begin
      next_cyc = '{kind: pppm_pkg::PPPM_K_FWD, lane: 2'h0,
                   cmd: mem[rp].cmd, data: mem[rp].data};
    end else if (rev_go) begin
      next_cyc = '{kind: pppm_pkg::PPPM_K_REV, lane: 2'h0, cmd: 1'b0, data: 8'h00};
    end
  end

  // cycle engine: raise request, wait ack high, then ack low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st      <= pppm_pkg::PPPM_IDLE;
      per_cyc <= '{kind: pppm_pkg::PPPM_K_ADDR_WR, lane: 2'h0, cmd: 1'b0, data: 8'h00};
    end else begin
      per_cyc <= next_cyc;
      case (st)
        pppm_pkg::PPPM_IDLE: begin
          if (epp_go || fwd_go || rev_go) begin
            st <= pppm_pkg::PPPM_REQ;
          end
        end
        pppm_pkg::PPPM_REQ: begin
          if (ack_s[1]) begin
            st <= pppm_pkg::PPPM_REL;
          end
        end
        pppm_pkg::PPPM_REL: begin
          if (!ack_s[1]) begin
            st <= pppm_pkg::PPPM_IDLE;
          end
        end
        default: st <= pppm_pkg::PPPM_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------
  // EPP address and transfer word
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      epp_addr <= 8'h00;
      epp_word <= 32'h0000_0000;
    end else if (epp_go && wr && addr == pppm_pkg::OFS_EPP_ADDR) begin
      epp_addr <= wdata;
    end else if (epp_go && wr) begin
      epp_word[8*addr[1:0] +: 8] <= wdata;
    end else if (st == pppm_pkg::PPPM_REQ && ack_s[1]) begin
      if (per_cyc.kind == pppm_pkg::PPPM_K_ADDR_RD) begin
        epp_addr <= pd_s;
      end else if (per_cyc.kind == pppm_pkg::PPPM_K_DATA_RD) begin
        epp_word[8*per_cyc.lane +: 8] <= pd_s;
      end
    end
  end

  // -------------------------------------------------------------
  // data lines
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pd_out  <= 8'h00;
      pd_oe_n <= 1'b0;
    end else begin
      pd_out <= next_cyc.data;
      case (mode)
        pppm_pkg::PPPM_SPP,
        pppm_pkg::PPPM_PFIFO: pd_oe_n <= 1'b0;
        pppm_pkg::PPPM_EPP:   pd_oe_n <= !(next_cyc.kind == pppm_pkg::PPPM_K_ADDR_WR
                                        || next_cyc.kind == pppm_pkg::PPPM_K_DATA_WR);
        default:              pd_oe_n <= dir;
      endcase
    end
  end

  // -------------------------------------------------------------
  // read data, valid the cycle after the strobe
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= 8'h00;
      if (addr == pppm_pkg::OFS_DCR) begin
        rdata[pppm_pkg::DCR_DIR_BIT]  <= dir;
        rdata[pppm_pkg::DCR_BUSY_BIT] <= !idle;
      end else if (addr == pppm_pkg::OFS_ECR) begin
        rdata[pppm_pkg::ECR_MODE_HI:pppm_pkg::ECR_MODE_LO] <= mode;
        rdata[pppm_pkg::ECR_FULL_BIT]  <= full;
        rdata[pppm_pkg::ECR_EMPTY_BIT] <= empty;
      end else if (in_epp && addr == pppm_pkg::OFS_EPP_ADDR) begin
        rdata <= epp_addr;
      end else if (in_epp && is_epp(addr)) begin
        rdata <= epp_word[8*addr[1:0] +: 8];
      end else if (addr == pppm_pkg::OFS_QUEUE && (qs == pppm_pkg::PPPM_Q_PAYR
                   || qs == pppm_pkg::PPPM_Q_LOOP)) begin
        rdata <= mem[rp].data;
      end
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  property p_epp_only;
    @(posedge clk) disable iff (!rstn)
      $rose(per_req) && per_cyc.kind inside {pppm_pkg::PPPM_K_ADDR_WR, pppm_pkg::PPPM_K_DATA_RD,
        pppm_pkg::PPPM_K_ADDR_RD, pppm_pkg::PPPM_K_DATA_WR} |-> $past(mode) == pppm_pkg::PPPM_EPP;
  endproperty
  a_epp_only: assert property (p_epp_only) else $error("epp cycle outside epp mode");

  property p_addr_cycle;
    @(posedge clk) disable iff (!rstn)
      idle && in_epp && wr && addr == pppm_pkg::OFS_EPP_ADDR
      |=> per_req && per_cyc.kind == pppm_pkg::PPPM_K_ADDR_WR && per_cyc.data == $past(wdata);
  endproperty
  a_addr_cycle: assert property (p_addr_cycle) else $error("address cycle not launched");

  property p_lane_cycle;
    @(posedge clk) disable iff (!rstn)
      idle && in_epp && (wr || rd) && addr >= pppm_pkg::OFS_LANE0 && addr <= pppm_pkg::OFS_LANE3
      |=> per_req && per_cyc.lane == $past(addr[1:0]) ##1 per_req || st == pppm_pkg::PPPM_REL;
  endproperty
  a_lane_cycle: assert property (p_lane_cycle) else $error("lane cycle wrong");

  property p_cmd_tag;
    @(posedge clk) disable iff (!rstn)
      wr && addr == pppm_pkg::OFS_CMDQ && in_ecp && !dir && !full |=> mem[$past(wp)].cmd;
  endproperty
  a_cmd_tag: assert property (p_cmd_tag) else $error("command byte not tagged");

  property p_cmd_rev;
    @(posedge clk) disable iff (!rstn)
      wr && addr == pppm_pkg::OFS_CMDQ && in_ecp && dir |=> wp == $past(wp) || !mem[$past(wp)].cmd;
  endproperty
  a_cmd_rev: assert property (p_cmd_rev) else $error("reverse command write took effect");

  property p_rev_fill;
    @(posedge clk) disable iff (!rstn)
      idle && in_ecp && dir && !full |=> per_req && per_cyc.kind == pppm_pkg::PPPM_K_REV;
  endproperty
  a_rev_fill: assert property (p_rev_fill) else $error("no fill cycle");

  property p_rev_pop;
    @(posedge clk) disable iff (!rstn)
      rd && addr == pppm_pkg::OFS_QUEUE && in_ecp && dir && !empty
      |=> rdata == mem[$past(rp)].data && rp == $past(rp) + 1'b1;
  endproperty
  a_rev_pop: assert property (p_rev_pop) else $error("reverse read did not pop");

  property p_test_quiet;
    @(posedge clk) disable iff (!rstn)
      mode == pppm_pkg::PPPM_TEST && idle |=> !per_req;
  endproperty
  a_test_quiet: assert property (p_test_quiet) else $error("cable cycle in test mode");

  property p_test_full;
    @(posedge clk) disable iff (!rstn)
      mode == pppm_pkg::PPPM_TEST && wr && addr == pppm_pkg::OFS_QUEUE && full |=> cnt == $past(cnt);
  endproperty
  a_test_full: assert property (p_test_full) else $error("write to full fifo took effect");

  property p_test_drive;
    @(posedge clk) disable iff (!rstn)
      mode == pppm_pkg::PPPM_TEST && !dir ##1 mode == pppm_pkg::PPPM_TEST |-> !pd_oe_n;
  endproperty
  a_test_drive: assert property (p_test_drive) else $error("data lines not driven");

  property p_loop_head;
    @(posedge clk) disable iff (!rstn)
      mode == pppm_pkg::PPPM_TEST && rd && addr == pppm_pkg::OFS_QUEUE && !empty
      |=> rdata == mem[$past(rp)].data;
  endproperty
  a_loop_head: assert property (p_loop_head) else $error("loopback read not from head");

  property p_compat_rd;
    @(posedge clk) disable iff (!rstn)
      mode == pppm_pkg::PPPM_PFIFO && rd && addr == pppm_pkg::OFS_QUEUE
      |=> rdata == 8'h00;
  endproperty
  a_compat_rd: assert property (p_compat_rd) else $error("compat queue read returned data");
endmodule : pppm_data_regs

// *** dv/pppm_periph_model.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// cable peripheral: logs each cycle, acks it, returns queued bytes
// ------------------------------------------------------------
module pppm_periph_model (
  // clock and cycle handshake
  input  wire logic                clk,
  input  wire logic                per_req,
  input  wire pppm_pkg::pppm_cyc_t per_cyc,
  output logic                     per_ack,
  // data lines and ack delay
  output logic [7:0]               pd_in,
  input  wire logic [3:0]          dly
);
  pppm_pkg::pppm_cyc_t seen_q[$];
  logic [7:0]          rd_q[$];

  // one cycle at a time: settle data, ack, hold until the request drops
  initial begin
    per_ack = 1'b0;
    pd_in   = 8'h00;
    forever begin
      @(posedge clk);
      if (per_req) begin
        seen_q.push_back(per_cyc);
        repeat (dly) @(posedge clk);
        pd_in <= (rd_q.size() > 0) ? rd_q.pop_front() : 8'h00;
        @(posedge clk);
        per_ack <= 1'b1;
        while (per_req) @(posedge clk);
        per_ack <= 1'b0;
        pd_in   <= ~pd_in;  // released lines show no stale byte
      end
    end
  end
endmodule : pppm_periph_model

// *** dv/tb_pppm_data_regs.sv ***
`timescale 1ns/100ps
module tb_pppm_data_regs;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  localparam logic [13:0] M_K   = 14'h3800;  // kind only
  localparam logic [13:0] M_KD  = 14'h38FF;  // kind and byte
  localparam logic [13:0] M_KCD = 14'h39FF;  // kind, tag and byte
  localparam logic [13:0] M_KL  = 14'h3E00;  // kind and lane
  localparam logic [13:0] M_KLD = 14'h3EFF;  // kind, lane and byte
  logic                clk, rstn, wr, rd, per_req, per_ack, pd_oe_n;
  logic [3:0]          addr, dly;
  logic [7:0]          wdata, rdata, pd_in, pd_out, v;
  pppm_pkg::pppm_cyc_t per_cyc;
  int                  err_total, tests_run;

  pppm_data_regs dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .per_req(per_req), .per_cyc(per_cyc), .per_ack(per_ack), .pd_in(pd_in), .pd_out(pd_out), .pd_oe_n(pd_oe_n));
  pppm_periph_model per (.clk(clk), .per_req(per_req), .per_cyc(per_cyc), .per_ack(per_ack), .pd_in(pd_in),
    .dly(dly));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // bus tasks and compares
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd_reg

  task automatic exp_cyc(input pppm_pkg::pppm_kind_t k, input logic c, input logic [1:0] ln,
                         input logic [7:0] d, input logic [13:0] m);
    pppm_pkg::pppm_cyc_t w, g;
    w = '{kind: k, lane: ln, cmd: c, data: d};
    g = '1;
    for (int n = 0; n < 300 && per.seen_q.size() == 0; n++) @(posedge clk);
    if (per.seen_q.size() > 0) g = per.seen_q.pop_front();
    check("per_cyc", 16'(w & m), 16'(g & m));
  endtask : exp_cyc

  // poll the busy flag of the control register
  task automatic wait_idle();
    logic [7:0] s;
    s = 8'h01;
    repeat (4) @(posedge clk);
    for (int n = 0; n < 100 && s[0] !== 1'b0; n++) rd_reg(4'h2, s);
  endtask : wait_idle

  task automatic quiet(input int c);
    repeat (c) @(posedge clk);
    check("cycle_count", 16'h0000, 16'(per.seen_q.size()));
  endtask : quiet

  task automatic complete_run();
    if (err_total == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  // watchdog against a hang
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    complete_run();
  end

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    rstn = 1'b0; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 8'h00; dly = 4'h0;
    err_total = 0; tests_run = 0;
    repeat (6) @(posedge clk);
    check("reset_out", 16'h0000, 16'({per_req, pd_oe_n, rdata}));
    rstn <= 1'b1;
    @(posedge clk);
    rd_reg(4'hA, v); check("ext_ctrl", 16'h0001, 16'(v));
    wr_reg(4'hF, 8'hFF); rd_reg(4'hF, v); check("unmapped", 16'h0000, 16'(v));
    // address and lane ports outside their mode
    wr_reg(4'h3, 8'h12); rd_reg(4'h4, v); check("lane_off", 16'h0000, 16'(v));
    quiet(20);
    // lane ports with a slow peripheral
    dly <= 4'h6;
    wr_reg(4'hA, 8'h80);
    wr_reg(4'h3, 8'hA5); exp_cyc(pppm_pkg::PPPM_K_ADDR_WR, 1'b0, 2'd0, 8'hA5, M_KD); wait_idle();
    for (int n = 0; n < 4; n++) begin
      wr_reg(4'(4 + n), 8'(8'h10 + n)); exp_cyc(pppm_pkg::PPPM_K_DATA_WR, 1'b0, 2'(n), 8'(8'h10 + n), M_KLD);
      wait_idle();
      per.rd_q.push_back(8'(8'hB0 + n));
      rd_reg(4'(4 + n), v); check("lane_rd", 16'(8'h10 + n), 16'(v));
      exp_cyc(pppm_pkg::PPPM_K_DATA_RD, 1'b0, 2'(n), 8'h00, M_KL); wait_idle();
      rd_reg(4'(4 + n), v); check("lane_cap", 16'(8'hB0 + n), 16'(v));
      exp_cyc(pppm_pkg::PPPM_K_DATA_RD, 1'b0, 2'(n), 8'h00, M_KL); wait_idle();
    end
    // second access while busy is dropped
    wr_reg(4'h4, 8'h37); wr_reg(4'h5, 8'h88);
    exp_cyc(pppm_pkg::PPPM_K_DATA_WR, 1'b0, 2'd0, 8'h37, M_KLD); wait_idle(); quiet(1);
    // address port read: old address now, captured byte on the next read
    per.rd_q.push_back(8'h5A);
    rd_reg(4'h3, v); check("addr_rd", 16'h00A5, 16'(v));
    exp_cyc(pppm_pkg::PPPM_K_ADDR_RD, 1'b0, 2'd0, 8'h00, M_K); wait_idle();
    rd_reg(4'h3, v); check("addr_cap", 16'h005A, 16'(v));
    exp_cyc(pppm_pkg::PPPM_K_ADDR_RD, 1'b0, 2'd0, 8'h00, M_K); wait_idle();
    // software re-enable sequence: index, read, set bit 6, write back
    wr_reg(4'h3, 8'h05); exp_cyc(pppm_pkg::PPPM_K_ADDR_WR, 1'b0, 2'd0, 8'h05, M_KD); wait_idle();
    rd_reg(4'h4, v); check("index_rd", 16'h0037, 16'(v)); wait_idle(); void'(per.seen_q.pop_front());
    wr_reg(4'h4, v | 8'h40); exp_cyc(pppm_pkg::PPPM_K_DATA_WR, 1'b0, 2'd0, 8'h77, M_KLD); wait_idle();
    // queue writes in the wrong mode, then forward queue traffic
    wr_reg(4'h0, 8'hC0); wr_reg(4'h8, 8'hD0);
    dly <= 4'h0;
    wr_reg(4'hA, 8'h60);
    wr_reg(4'h0, 8'hC1); wr_reg(4'h8, 8'hD1); rd_reg(4'h8, v); check("payf_rd", 16'h0000, 16'(v));
    exp_cyc(pppm_pkg::PPPM_K_FWD, 1'b1, 2'd0, 8'hC1, M_KCD);
    exp_cyc(pppm_pkg::PPPM_K_FWD, 1'b0, 2'd0, 8'hD1, M_KCD);
    wait_idle(); quiet(10);
    // backward direction fills the queue by itself
    wr_reg(4'hA, 8'h00); wr_reg(4'h2, 8'h20);
    for (int i = 0; i < 16; i++) per.rd_q.push_back(8'(8'h40 + i));
    wr_reg(4'hA, 8'h60);
    wr_reg(4'h0, 8'hFF); wr_reg(4'h8, 8'hEE);
    repeat (400) @(posedge clk);
    rd_reg(4'hA, v); check("ext_ctrl", 16'h0062, 16'(v));
    for (int i = 0; i < 16; i++) exp_cyc(pppm_pkg::PPPM_K_REV, 1'b0, 2'd0, 8'h00, M_K);
    for (int i = 0; i < 16; i++) begin
      rd_reg(4'h8, v); check("rev_pop", 16'(8'h40 + i), 16'(v));
    end
    wr_reg(4'hA, 8'h00); wait_idle(); per.seen_q.delete(); wr_reg(4'h2, 8'h00);
    // compatibility queue, forward only
    wr_reg(4'hA, 8'h40);
    wr_reg(4'h8, 8'h31); wr_reg(4'h8, 8'h32); rd_reg(4'h8, v); check("compat_rd", 16'h0000, 16'(v));
    exp_cyc(pppm_pkg::PPPM_K_FWD, 1'b0, 2'd0, 8'h31, M_KCD);
    exp_cyc(pppm_pkg::PPPM_K_FWD, 1'b0, 2'd0, 8'h32, M_KCD); wait_idle();
    check("pd_out", 16'h0032, 16'(pd_out));
    // loopback queue: overfill, drain across a direction change, underrun
    wr_reg(4'hA, 8'hC0);
    for (int i = 0; i < 17; i++) wr_reg(4'h8, 8'(8'h50 + i));
    rd_reg(4'hA, v); check("ext_ctrl", 16'h00C2, 16'(v));
    check("pd_oe_n", 16'h0000, 16'(pd_oe_n)); quiet(20);
    wr_reg(4'h2, 8'h20);
    for (int i = 0; i < 16; i++) begin
      rd_reg(4'h8, v); check("loop_pop", 16'(8'h50 + i), 16'(v));
    end
    rd_reg(4'h8, v); rd_reg(4'hA, v); check("ext_ctrl", 16'h00C1, 16'(v));
    wr_reg(4'h8, 8'h99); rd_reg(4'h8, v); check("loop_pop", 16'h0099, 16'(v)); quiet(4);
    complete_run();
  end
endmodule : tb_pppm_data_regs
